// ### common/lpgc_defines.svh
`ifndef LPGC_DEFINES_SVH
`define LPGC_DEFINES_SVH

// ----------------------------------------------------------------
// gearing and widths
// ----------------------------------------------------------------
`define LPGC_DQ_W 8
`define LPGC_CA_W 6
`define LPGC_CMD_W 7
`define LPGC_DATA_GEAR 8
`define LPGC_CMD_GEAR 4
`define LPGC_CLK_RATIO 4
`define LPGC_DLY_TAPS 4

// ----------------------------------------------------------------
// frequency select codes and rates
// ----------------------------------------------------------------
`define LPGC_SEL_OPER 3'h0
`define LPGC_SEL_TRAIN 3'h1
`define LPGC_TRAIN_MHZ 50
`define LPGC_DEFAULT_MHZ 533
`define LPGC_MAX_RATE_MBPS 1066

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LPGC_CLK_PERIOD_NS 4
`define LPGC_LOCK_TIME_NS 1000
`define LPGC_DLL_TIME_NS 8000
`define LPGC_LOCK_CYCLES \
    ((`LPGC_LOCK_TIME_NS + `LPGC_CLK_PERIOD_NS - 1) / `LPGC_CLK_PERIOD_NS)
`define LPGC_DLL_CYCLES \
    ((`LPGC_DLL_TIME_NS + `LPGC_CLK_PERIOD_NS - 1) / `LPGC_CLK_PERIOD_NS)

`endif

// ### common/lpgc_dly_if.sv
`timescale 1ns/1ps
interface lpgc_dly_if #(parameter int W = 8) ();
    logic [W-1:0] din;
    logic [2*W-1:0] code;
    logic [W-1:0] dout;
    modport unit(input din, input code, output dout);
    modport user(output din, output code, input dout);
endinterface

// ### common/lpgc_pkg.sv
package lpgc_pkg;

    typedef enum logic [1:0] {ST_LOCK, ST_DLL, ST_READY} lpgc_state_e;
    typedef logic [11:0] lpgc_count_t;

    // supported memory clock frequencies, and pin rate within limit
    function automatic bit lpgc_freq_ok(int mhz, int max_mbps);
        return (mhz inside {200, 250, 300, 350, 400, 533}) &&
            (2 * mhz <= max_mbps);
    endfunction

    // command/address beat k out of a four-beat system word
    function automatic logic [5:0] lpgc_ca_beat(logic [23:0] w,
        logic [1:0] k);
        return w[int'(k) * 6 +: 6];
    endfunction

endpackage

// ### rtl/lpgc_delay_line.sv
`timescale 1ns/1ps
`include "lpgc_defines.svh"
module lpgc_delay_line #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic reset,
    lpgc_dly_if.unit dl
);
    import lpgc_pkg::*;

    // ----------------------------------------------------------------
    // tap chain, tap 0 is the undelayed input
    // ----------------------------------------------------------------
    logic [W-1:0] tap [`LPGC_DLY_TAPS];

    assign tap[0] = dl.din;

    // one flop stage per tap after tap 0, each with its own single driver
    for (genvar k = 1; k < `LPGC_DLY_TAPS; k++) begin : g_tap
        logic [W-1:0] q;
        always_ff @(posedge core_clk) begin
            q <= reset ? '0 : tap[k-1];
        end
        assign tap[k] = q;
    end

    // each bit picks its own tap
    for (genvar i = 0; i < W; i++) begin : g_bit
        assign dl.dout[i] = tap[dl.code[2*i +: 2]][i];
    end

endmodule // lpgc_delay_line

// ### rtl/lpgc_phy_top.sv
// Operation
// - memory clock runs four times the system clock rate
// - eight-bit system lane per pin, four memory clocks, both edges
// - command signals four wide, change on memory clock falling edge at both operating and training rate
// - pin data rate limited to 1066 Mbps
// - operating frequency one of 200, 250, 300, 350, 400, 533 MHz
// - each command output bit has its own adjustable delay; only cs and ca go through it, cke and odt bypass it
// - data path has group delay and per-bit delay; per-bit delay on write data bits only
// - group is eight data bits, strobe, mask; read, write, strobe paths
// - active-high reset puts block into reset state
// - system clock output is memory clock divided by four
// - select 0 gives operating frequency, 1 gives 50 MHz training
// - rising update request starts frequency change; held until ready
// - dll update enable adds slow dll update to the change
// - memory clock toggles only while its enable is high
// - ready drops during change, rises when both clocks valid
// - pll lock shows generated clocks are stable
// - separate low-active drive enables for clock pins and command pins
`timescale 1ns/1ps
`include "lpgc_defines.svh"
module lpgc_phy_top #(
    parameter int MEM_FREQ_MHZ = `LPGC_DEFAULT_MHZ
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic clock_update_request,
    input wire logic [2:0] mem_freq_select,
    input wire logic dll_update_enable,
    input wire logic mem_clock_toggle_enable,
    input wire logic clock_pins_drive_enable_low,
    input wire logic command_pins_drive_enable_low,
    input wire logic write_data_drive_enable_low,
    input wire logic [3:0] cke_word,
    input wire logic [3:0] cs_word,
    input wire logic [23:0] ca_word,
    input wire logic [3:0] odt_word,
    input wire logic [63:0] write_dq_word,
    input wire logic [7:0] write_dmi_word,
    input wire logic [7:0] write_dqs_word,
    input wire logic [13:0] cmd_bit_delay,
    input wire logic [15:0] dq_bit_delay,
    input wire lpgc_pkg::lpgc_count_t unused_count,
    input wire logic [1:0] write_group_delay,
    input wire logic [1:0] read_group_delay,
    input wire logic [1:0] strobe_group_delay,
    input wire logic [7:0] mem_dq_in,
    input wire logic mem_dqs_in,
    input wire logic mem_dmi_in,
    output logic pll_lock,
    output logic ready,
    output logic sys_clock_out,
    output logic mem_clock_out,
    output logic mem_clock_pins_oe,
    output logic mem_command_pins_oe,
    output logic mem_cke,
    output logic mem_cs,
    output logic [5:0] mem_ca,
    output logic mem_odt,
    output logic [7:0] mem_dq_out,
    output logic mem_dq_oe,
    output logic mem_dqs_out,
    output logic mem_dqs_oe,
    output logic mem_dmi_out,
    output logic mem_dmi_oe,
    output logic [63:0] read_dq_word,
    output logic [7:0] read_dmi_word,
    output logic read_valid
);
    import lpgc_pkg::*;

    // unsupported settings fall back to the default rate
    localparam int FREQ = lpgc_freq_ok(MEM_FREQ_MHZ, `LPGC_MAX_RATE_MBPS) ?
        MEM_FREQ_MHZ : `LPGC_DEFAULT_MHZ;
    localparam int TRAIN_DIV = FREQ / `LPGC_TRAIN_MHZ;
    localparam lpgc_count_t LOCK_CNT = lpgc_count_t'(`LPGC_LOCK_CYCLES);
    localparam lpgc_count_t DLL_CNT = lpgc_count_t'(`LPGC_DLL_CYCLES);
    localparam logic [3:0] DIV_LOAD = 4'(TRAIN_DIV - 1);

    // ----------------------------------------------------------------
    // synchronizers for the change request
    // ----------------------------------------------------------------
    logic [1:0] upd_sync;
    logic [2:0] sel_s1;
    logic [2:0] sel_s2;
    logic [1:0] dll_sync;
    logic upd_prev;
    wire upd_rise = upd_sync[1] & ~upd_prev;

    always_ff @(posedge core_clk) begin
        upd_sync <= reset ? 2'h0 : {upd_sync[0], clock_update_request};
        sel_s1 <= reset ? 3'h0 : mem_freq_select;
        sel_s2 <= reset ? 3'h0 : sel_s1;
        dll_sync <= reset ? 2'h0 : {dll_sync[0], dll_update_enable};
        upd_prev <= reset ? 1'h0 : upd_sync[1];
    end

    // ----------------------------------------------------------------
    // frequency change sequencer
    // ----------------------------------------------------------------
    lpgc_state_e st;
    lpgc_count_t wait_cnt;
    logic [2:0] sel_q;
    logic dll_q;
    wire wait_done = (wait_cnt == '0);
    wire running = (st == ST_READY);

    // select is only taken on the rising request edge; held stable by
    // the controller meanwhile, so a plain two-flop sync is safe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            st <= ST_LOCK;
            wait_cnt <= LOCK_CNT;
            sel_q <= `LPGC_SEL_OPER;
            dll_q <= 1'h0;
            pll_lock <= 1'h0;
            ready <= 1'h0;
        end else begin
            case (st)
                ST_READY: if (upd_rise) begin
                    st <= ST_LOCK;
                    wait_cnt <= LOCK_CNT;
                    sel_q <= sel_s2;
                    dll_q <= dll_sync[1];
                    pll_lock <= 1'h0;
                    ready <= 1'h0;
                end
                ST_LOCK: if (wait_done) begin
                    pll_lock <= 1'h1;
                    st <= dll_q ? ST_DLL : ST_READY;
                    wait_cnt <= DLL_CNT;
                    ready <= ~dll_q;
                end else begin
                    wait_cnt <= wait_cnt - 1'b1;
                end
                ST_DLL: if (wait_done) begin
                    st <= ST_READY;
                    ready <= 1'h1;
                end else begin
                    wait_cnt <= wait_cnt - 1'b1;
                end
                default: st <= ST_LOCK;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // clock generation: one tick per memory clock half period
    // ----------------------------------------------------------------
    logic [3:0] div_cnt;
    logic [2:0] ph;
    wire slow = (sel_q == `LPGC_SEL_TRAIN);
    wire tick = running & (~slow | (div_cnt == 4'h0));
    wire word_end = tick & (ph == 3'h7);
    wire load = ~running | word_end;
    wire fast_run = running & ~slow;

    always_ff @(posedge core_clk) begin
        if (reset || !running || tick) begin
            div_cnt <= reset || !running ? 4'h0 : DIV_LOAD;
        end else begin
            div_cnt <= div_cnt - 4'h1;
        end
        ph <= (reset || !running) ? 3'h0 : ph + 3'(tick);
    end

    // clocks stop while a change is in progress
    always_ff @(posedge core_clk) begin
        sys_clock_out <= ~reset & running & ~ph[2];
        mem_clock_out <= ~reset & running & ~ph[0] &
            mem_clock_toggle_enable;
        mem_clock_pins_oe <= ~reset & ~clock_pins_drive_enable_low;
        mem_command_pins_oe <= ~reset & ~command_pins_drive_enable_low;
        mem_dq_oe <= ~reset & ~write_data_drive_enable_low;
        mem_dqs_oe <= ~reset & ~write_data_drive_enable_low;
        mem_dmi_oe <= ~reset & ~write_data_drive_enable_low;
    end

    // ----------------------------------------------------------------
    // system word holding and serializers
    // ----------------------------------------------------------------
    logic [63:0] wq;
    logic [7:0] wm;
    logic [7:0] ws;
    logic [3:0] cke_h;
    logic [3:0] cs_h;
    logic [3:0] odt_h;
    logic [23:0] ca_h;
    logic [7:0] dq_ser;
    logic dm_ser;
    logic dqs_ser;
    logic [`LPGC_CMD_W-1:0] cmd_ser;
    logic cke_ser;
    logic odt_ser;

    always_ff @(posedge core_clk) begin
        if (load) begin
            wq <= write_dq_word;
            wm <= write_dmi_word;
            ws <= write_dqs_word;
            cke_h <= cke_word;
            cs_h <= cs_word;
            odt_h <= odt_word;
            ca_h <= ca_word;
        end
    end

    // data beat per tick, i.e. per memory clock edge
    always_ff @(posedge core_clk) begin
        if (reset) begin
            dq_ser <= 8'h0;
            dm_ser <= 1'h0;
            dqs_ser <= 1'h0;
        end else if (tick) begin
            dq_ser <= wq[{ph, 3'h0} +: `LPGC_DQ_W];
            dm_ser <= wm[ph];
            dqs_ser <= ws[ph];
        end
    end

    // launched on the even tick; the pin register adds one cycle, so the
    // pin changes as the memory clock falls, at the operating rate and at training rate alike
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cmd_ser <= '0;
            cke_ser <= 1'h0;
            odt_ser <= 1'h0;
        end else if (tick && !ph[0]) begin
            cmd_ser <= {cs_h[ph[2:1]], lpgc_ca_beat(ca_h, ph[2:1])};
            cke_ser <= cke_h[ph[2:1]];
            odt_ser <= odt_h[ph[2:1]];
        end
    end

    // ----------------------------------------------------------------
    // delay adjustment
    // ----------------------------------------------------------------
    lpgc_dly_if #(.W(`LPGC_CMD_W)) cmd_d ();
    lpgc_dly_if #(.W(`LPGC_DQ_W)) bit_d ();
    lpgc_dly_if #(.W(`LPGC_DQ_W + 1)) wgrp_d ();
    lpgc_dly_if #(.W(1)) sgrp_d ();
    lpgc_dly_if #(.W(`LPGC_DQ_W + 1)) rgrp_d ();

    assign cmd_d.din = cmd_ser;
    assign cmd_d.code = cmd_bit_delay;
    assign bit_d.din = dq_ser;
    assign bit_d.code = dq_bit_delay;
    assign wgrp_d.din = {dm_ser, bit_d.dout};
    assign wgrp_d.code = {(`LPGC_DQ_W + 1){write_group_delay}};
    assign sgrp_d.din = dqs_ser;
    assign sgrp_d.code = strobe_group_delay;
    assign rgrp_d.din = {mem_dmi_in, mem_dq_in};
    assign rgrp_d.code = {(`LPGC_DQ_W + 1){read_group_delay}};

    lpgc_delay_line #(.W(`LPGC_CMD_W)) u_cmd_dly (.core_clk(core_clk),
        .reset(reset), .dl(cmd_d.unit));
    lpgc_delay_line #(.W(`LPGC_DQ_W)) u_bit_dly (.core_clk(core_clk),
        .reset(reset), .dl(bit_d.unit));
    lpgc_delay_line #(.W(`LPGC_DQ_W + 1)) u_wgrp_dly (.core_clk(core_clk),
        .reset(reset), .dl(wgrp_d.unit));
    lpgc_delay_line #(.W(1)) u_sgrp_dly (.core_clk(core_clk),
        .reset(reset), .dl(sgrp_d.unit));
    lpgc_delay_line #(.W(`LPGC_DQ_W + 1)) u_rgrp_dly (.core_clk(core_clk),
        .reset(reset), .dl(rgrp_d.unit));

    always_ff @(posedge core_clk) begin
        mem_cs <= ~reset & cmd_d.dout[`LPGC_CA_W];
        mem_ca <= reset ? 6'h0 : cmd_d.dout[`LPGC_CA_W-1:0];
        mem_cke <= ~reset & cke_ser;
        mem_odt <= ~reset & odt_ser;
        mem_dq_out <= reset ? 8'h0 : wgrp_d.dout[`LPGC_DQ_W-1:0];
        mem_dmi_out <= ~reset & wgrp_d.dout[`LPGC_DQ_W];
        mem_dqs_out <= ~reset & sgrp_d.dout[0];
    end

    // ----------------------------------------------------------------
    // read deserializer; word valid only if the strobe moved
    // ----------------------------------------------------------------
    logic [63:0] rd_buf;
    logic [7:0] rm_buf;
    logic dqs_prev;
    logic dqs_seen;
    wire word_start = tick & (ph == 3'h0);

    always_ff @(posedge core_clk) begin
        dqs_prev <= ~reset & mem_dqs_in;
        if (reset || word_start) begin
            dqs_seen <= 1'h0;
        end else begin
            dqs_seen <= dqs_seen | (dqs_prev ^ mem_dqs_in);
        end
        if (tick) begin
            rd_buf[{ph, 3'h0} +: `LPGC_DQ_W] <= rgrp_d.dout[`LPGC_DQ_W-1:0];
            rm_buf[ph] <= rgrp_d.dout[`LPGC_DQ_W];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            read_dq_word <= 64'h0;
            read_dmi_word <= 8'h0;
            read_valid <= 1'h0;
        end else begin
            read_valid <= word_start & dqs_seen;
            if (word_start) begin
                read_dq_word <= rd_buf;
                read_dmi_word <= rm_buf;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_change_start;
        running && upd_rise;
    endsequence
    sequence s_fast8;
        fast_run [*8];
    endsequence

    property p_ready_drop;
        s_change_start |=> !ready && !pll_lock ##1 !ready [*3];
    endproperty
    a_ready_drop: assert property (p_ready_drop)
        else $error("ready did not drop on clock change");

    property p_sys_ratio;
        $rose(sys_clock_out) ##1 s_fast8 |-> $rose(sys_clock_out);
    endproperty
    a_sys_ratio: assert property (p_sys_ratio)
        else $error("system clock period not four memory clocks");

    property p_clk_gate;
        !mem_clock_toggle_enable |=> !mem_clock_out;
    endproperty
    a_clk_gate: assert property (p_clk_gate)
        else $error("memory clock toggled while disabled");

    property p_ready_lock;
        ready |-> pll_lock && running;
    endproperty
    a_ready_lock: assert property (p_ready_lock)
        else $error("ready without lock");

    property p_cmd_fall;
        $changed(cmd_ser) |-> !$past(ph[0]) && $past(tick);
    endproperty
    a_cmd_fall: assert property (p_cmd_fall)
        else $error("command changed away from falling edge");

    property p_ck_oe;
        clock_pins_drive_enable_low |=> !mem_clock_pins_oe;
    endproperty
    a_ck_oe: assert property (p_ck_oe)
        else $error("clock pins driven while disabled");

    property p_ca_oe;
        !command_pins_drive_enable_low |=> mem_command_pins_oe;
    endproperty
    a_ca_oe: assert property (p_ca_oe)
        else $error("command pins not driven while enabled");

    property p_train_slow;
        tick && slow |=> !tick [*3];
    endproperty
    a_train_slow: assert property (p_train_slow)
        else $error("training rate ticks too fast");

    property p_lock_wait;
        $fell(pll_lock) |-> !pll_lock [*8];
    endproperty
    a_lock_wait: assert property (p_lock_wait)
        else $error("lock returned too soon");

endmodule // lpgc_phy_top

// ### sim/lpgc_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// memory-side read responder
// ----------------------------------------------------------------
module lpgc_mem_model (
    input wire logic core_clk,
    input wire logic mem_dq_oe,
    input wire logic read_burst,
    output logic [7:0] mem_dq_in,
    output logic mem_dqs_in,
    output logic mem_dmi_in
);
    initial begin
        mem_dq_in = 8'h3c;
        mem_dqs_in = 1'b0;
        mem_dmi_in = 1'b0;
    end
    always @(posedge core_clk) begin
        if (read_burst && !mem_dq_oe) begin
            mem_dq_in <= mem_dq_in + 8'h1;
            mem_dqs_in <= !mem_dqs_in;
            mem_dmi_in <= 1'b0;
        end else begin
            // released: invert so a stale byte never looks held
            mem_dq_in <= ~mem_dq_in;
            // strobe parks low between bursts
            mem_dqs_in <= 1'b0;
            mem_dmi_in <= ~mem_dmi_in;
        end
    end
endmodule // lpgc_mem_model

// ### sim/lpgc_phy_top_bench.sv
`timescale 1ns/1ps
module lpgc_phy_top_bench;
    import lpgc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic req = 1'b0, dll_en = 1'b0, tog_en = 1'b1, burst = 1'b0;
    logic ck_low = 1'b0, ca_low = 1'b0, wr_low = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [3:0] cke_w = 4'h0, cs_w = 4'h0, odt_w = 4'h0;
    logic [23:0] ca_w = 24'h0;
    logic [63:0] dq_w = 64'h0, rd_word;
    logic [7:0] dmi_w = 8'h0, dqs_w = 8'h0, dq_in, dq_out;
    logic [13:0] cmd_dly = 14'h0;
    logic [15:0] dq_dly = 16'h0;
    logic [1:0] wr_gd = 2'h0, rd_gd = 2'h0, st_gd = 2'h0;
    logic [5:0] mem_ca;
    logic pll_lock, ready, sys_clk, mem_clk, ck_oe, ca_oe, dq_oe;
    logic dqs_in, dmi_in, rd_valid;
    int n_mismatch = 0;
    int n_compared = 0;

    lpgc_phy_top i_dut (
        .core_clk(core_clk), .reset(reset),
        .clock_update_request(req), .mem_freq_select(sel),
        .dll_update_enable(dll_en), .mem_clock_toggle_enable(tog_en),
        .clock_pins_drive_enable_low(ck_low),
        .command_pins_drive_enable_low(ca_low),
        .write_data_drive_enable_low(wr_low),
        .cke_word(cke_w), .cs_word(cs_w), .ca_word(ca_w),
        .odt_word(odt_w), .write_dq_word(dq_w),
        .write_dmi_word(dmi_w), .write_dqs_word(dqs_w),
        .cmd_bit_delay(cmd_dly), .dq_bit_delay(dq_dly),
        .unused_count(lpgc_count_t'(0)), .write_group_delay(wr_gd),
        .read_group_delay(rd_gd), .strobe_group_delay(st_gd),
        .mem_dq_in(dq_in), .mem_dqs_in(dqs_in), .mem_dmi_in(dmi_in),
        .pll_lock(pll_lock), .ready(ready), .sys_clock_out(sys_clk),
        .mem_clock_out(mem_clk), .mem_clock_pins_oe(ck_oe),
        .mem_command_pins_oe(ca_oe), .mem_cke(), .mem_cs(),
        .mem_ca(mem_ca), .mem_odt(), .mem_dq_out(dq_out),
        .mem_dq_oe(dq_oe), .mem_dqs_out(), .mem_dqs_oe(),
        .mem_dmi_out(), .mem_dmi_oe(), .read_dq_word(rd_word),
        .read_dmi_word(), .read_valid(rd_valid)
    );

    lpgc_mem_model i_mem (
        .core_clk(core_clk), .mem_dq_oe(dq_oe), .read_burst(burst),
        .mem_dq_in(dq_in), .mem_dqs_in(dqs_in), .mem_dmi_in(dmi_in)
    );

    // ----------------------------------------------------------------
    // shared helpers
    // ----------------------------------------------------------------
    initial begin
        forever #2 core_clk = ~core_clk;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
        input string what);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask

    task automatic sample();
        @(posedge core_clk);
        #1;
    endtask

    task automatic wait_ready(input logic lvl, input int lim, output int n);
        n = 0;
        while (ready !== lvl) begin
            sample();
            n++;
            if (n > lim) begin
                check(0, 1, "ready wait ran out");
                finish_test();
            end
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        int n;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (8) sample();
        check(ready, 0, "ready in reset");
        check(pll_lock, 0, "lock in reset");
        check({mem_clk, sys_clk}, 0, "clocks in reset");
        @(posedge core_clk);
        reset <= 1'b0;
        wait_ready(1'b1, 400, n);
        check(n >= 248 && n <= 256, 1, "lock time");
        check(pll_lock, 1, "lock with ready");
    endtask

    task automatic t_clocks(input int cyc, input int e_tog, input int e_sys);
        int tog = 0;
        int rise = 0;
        logic m, s;
        sample();
        m = mem_clk;
        s = sys_clk;
        repeat (cyc) begin
            sample();
            tog += int'(mem_clk !== m);
            rise += int'(sys_clk === 1'b1 && s === 1'b0);
            m = mem_clk;
            s = sys_clk;
        end
        check(tog, e_tog, "memory clock toggles");
        check(rise, e_sys, "system clock rises");
    endtask

    task automatic t_toggle();
        @(posedge core_clk);
        tog_en <= 1'b0;
        t_clocks(32, 0, 4);
        @(posedge core_clk);
        tog_en <= 1'b1;
    endtask

    task automatic t_oe();
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            ck_low <= i[0];
            ca_low <= i[1];
            repeat (4) sample();
            check(ck_oe, !i[0], "clock pin drive");
            check(ca_oe, !i[1], "command pin drive");
        end
    endtask

    task automatic t_serial(input logic [1:0] gd, input logic [15:0] bd,
        input logic [13:0] cd);
        logic [7:0] prev;
        logic [5:0] ca_prev;
        int run = 0;
        int best = 0;
        int bad = 0;
        int chg = 0;
        @(posedge core_clk);
        ck_low <= 1'b0;
        ca_low <= 1'b0;
        wr_low <= 1'b0;
        wr_gd <= gd;
        st_gd <= gd;
        dq_dly <= bd;
        cmd_dly <= cd;
        dq_w <= 64'ha7a6a5a4a3a2a1a0;
        ca_w <= {6'h30, 6'h0f, 6'h2a, 6'h15};
        cs_w <= 4'h5;
        cke_w <= 4'hf;
        odt_w <= 4'h3;
        dmi_w <= 8'h0f;
        dqs_w <= 8'h55;
        repeat (24) sample();
        prev = dq_out;
        ca_prev = mem_ca;
        repeat (64) begin
            sample();
            run = (dq_out === prev + 8'h1) ? run + 1 : 0;
            best = (run > best) ? run : best;
            chg += int'(mem_ca !== ca_prev);
            bad += int'(mem_ca !== ca_prev && mem_clk !== 1'b0);
            prev = dq_out;
            ca_prev = mem_ca;
        end
        check(best >= 7, 1, "data beats in order");
        check(chg, 32, "command beat held two ticks");
        check(bad, 0, "command change off falling edge");
        check(dq_oe, 1, "data pins driven");
    endtask

    task automatic t_read();
        int seen = 0;
        logic [63:0] last;
        last = '0;
        @(posedge core_clk);
        wr_low <= 1'b1;
        rd_gd <= 2'h1;
        burst <= 1'b1;
        repeat (32) begin
            sample();
            seen += int'(rd_valid === 1'b1);
            if (rd_valid === 1'b1) begin
                last = rd_word;
            end
        end
        check(seen > 0, 1, "read word delivered");
        check(last[15:8], 8'(last[7:0] + 8'h1), "read beat order");
        check(last[63:56], 8'(last[7:0] + 8'h7), "read word span");
        @(posedge core_clk);
        burst <= 1'b0;
        wr_low <= 1'b0;
    endtask

    task automatic t_change(input logic [2:0] s, input logic d,
        input int lo, input int hi);
        int n;
        @(posedge core_clk);
        sel <= s;
        dll_en <= d;
        req <= 1'b1;
        wait_ready(1'b0, 8, n);
        check(pll_lock, 0, "lock drops in change");
        wait_ready(1'b1, 2400, n);
        check(n >= lo && n <= hi, 1, "change time");
        check(pll_lock, 1, "lock after change");
        @(posedge core_clk);
        req <= 1'b0;
    endtask

    initial begin
        t_reset();
        t_clocks(32, 32, 4);
        t_toggle();
        t_oe();
        t_serial(2'h0, 16'h0000, 14'h0000);
        // uniform taps keep beat order and edge alignment
        t_serial(2'h1, 16'h5555, 14'h2aaa);
        t_read();
        t_change(3'h1, 1'b0, 249, 253);
        t_clocks(80, 8, 1);
        t_change(3'h0, 1'b1, 2250, 2254);
        t_clocks(32, 32, 4);
        t_reset();
        finish_test();
    end
endmodule // lpgc_phy_top_bench
